/* rtl/eu_uart.sv */
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module eu_uart import eu_pkg::*; #(
    parameter int CPU_DIV = 1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [4:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd,
    input wire logic t1_ovf,
    output logic break_reset
);
    // Frame length after the start bit
    function automatic logic [3:0] frame_bits(input logic [1:0] m);
        frame_bits = (m == MODE_8) ? BITS_8 : BITS_9;
    endfunction
    // Address decode, used by the slave error flag
    function automatic logic mapped(input logic [4:0] a);
        case (a)
            ADDR_CTRL, ADDR_STAT, ADDR_PWR, ADDR_DIVL: mapped = 1'b1;
            ADDR_DIVH, ADDR_SRC, ADDR_DATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    eu_ctrl_t ctrl_reg; // Serial control fields
    logic fe_reg; // Sticky framing error
    logic brk_reg; // Sticky break seen
    logic bd_reg; // Baud doubling select
    logic fes_reg; // Framing error select
    logic src_reg; // 1: generator, 0: Timer 1
    logic [7:0] divl_reg;
    logic [7:0] divh_reg;
    logic [7:0] rx_data_reg; // Last received byte
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [1:0] mode;
    logic acc;
    logic wr;
    logic [31:0] rd_data;
    eu_tx_t tx_st; // Transmitter state, read by the status mux

    assign mode = {ctrl_reg.msh, ctrl_reg.msl};
    // Access completes on the edge where pready is seen high
    assign acc = psel & penable & pready_reg;
    assign wr = acc & pwrite;

    // CPU clock as an enable derived from the oscillator clock
    logic [7:0] cdiv_reg;
    logic cpu_tick;
    assign cpu_tick = cdiv_reg == 8'(CPU_DIV - 1);
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cdiv_reg <= 8'h00;
        end else if (ce) begin
            cdiv_reg <= cpu_tick ? 8'h00 : cdiv_reg + 8'h01;
        end
    end

    // Generator: free-running down counter on the oscillator
    logic [15:0] brg_cnt_reg;
    logic brg_tick;
    assign brg_tick = brg_cnt_reg == 16'h0000;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            brg_cnt_reg <= 16'h0000;
        end else if (ce) begin
            // Reload from the joined divisor pair
            brg_cnt_reg <= brg_tick ? {divh_reg, divl_reg} : brg_cnt_reg - 16'h0001;
        end
    end

    // Prescalers for Timer 1 path and fixed 9-bit mode
    logic t1_half_reg;
    logic cpu_half_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            t1_half_reg <= 1'b0;
            cpu_half_reg <= 1'b0;
        end else if (ce) begin
            if (t1_ovf) begin
                t1_half_reg <= ~t1_half_reg;
            end
            if (cpu_tick) begin
                cpu_half_reg <= ~cpu_half_reg;
            end
        end
    end

    // Oversample tick, sixteen per bit in every mode
    logic t1_tick;
    logic var_tick;
    logic os_tick;
    // Halve the overflow rate when doubling is set
    assign t1_tick = t1_ovf & (~bd_reg | t1_half_reg);
    // Only Timer 1 or the generator; no Timer 2 path exists
    assign var_tick = src_reg ? brg_tick : t1_tick;
    always_comb begin
        case (mode)
            MODE_SHIFT: os_tick = cpu_tick; // Bit = cpu/16
            MODE_9F: os_tick = cpu_tick & (bd_reg | cpu_half_reg);
            default: os_tick = var_tick; // Modes 1 and 3
        endcase
    end

    // APB slave: one wait state, read data captured early
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else if (ce) begin
            pready_reg <= psel & penable & ~pready_reg;
            if (psel & penable & ~pready_reg) begin
                pslverr_reg <= ~mapped(paddr);
                prdata_reg <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        rd_data = 32'h0000_0000;
        case (paddr)
            ADDR_CTRL: begin
                rd_data[7:0] = {ctrl_reg.msh, ctrl_reg.msl, 1'b0, ctrl_reg.ren,
                                ctrl_reg.tnb, ctrl_reg.rnb, ctrl_reg.ti, ctrl_reg.ri};
                // Bit 7 shows the error when selected
                rd_data[7] = fes_reg ? fe_reg : ctrl_reg.msh;
            end
            ADDR_STAT: begin
                rd_data[STAT_FE] = fe_reg;
                rd_data[STAT_BRK] = brk_reg;
                rd_data[STAT_TXB] = tx_st != TX_IDLE;
            end
            ADDR_PWR: begin
                rd_data[PWR_BD] = bd_reg;
                rd_data[PWR_FES] = fes_reg;
            end
            ADDR_DIVL: rd_data[7:0] = divl_reg;
            ADDR_DIVH: rd_data[7:0] = divh_reg;
            ADDR_SRC: rd_data[SRC_BRG] = src_reg;
            ADDR_DATA: rd_data[7:0] = rx_data_reg;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // Power control, divisors and source select
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bd_reg <= 1'b0;
            fes_reg <= 1'b0;
            src_reg <= 1'b0;
            divl_reg <= 8'h00;
            divh_reg <= 8'h00;
        end else if (ce && wr) begin
            case (paddr)
                ADDR_PWR: begin
                    bd_reg <= pwdata[PWR_BD];
                    fes_reg <= pwdata[PWR_FES];
                end
                ADDR_DIVL: divl_reg <= pwdata[7:0];
                ADDR_DIVH: divh_reg <= pwdata[7:0];
                ADDR_SRC: src_reg <= pwdata[SRC_BRG];
                default: ;
            endcase
        end
    end

    // Pulses from the shift engines
    logic tx_done_reg;
    logic m0_done_reg;
    logic rx_done_reg;
    logic rnb_val_reg;
    logic fe_set_reg;
    logic break_reset_reg;

    // Control register; hardware sets beat software clears
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
        end else if (ce) begin
            if (wr && paddr == ADDR_CTRL) begin
                // Mode bit 7 is only writable outside the error view
                if (!fes_reg) begin
                    ctrl_reg.msh <= pwdata[7];
                end
                ctrl_reg.msl <= pwdata[6];
                ctrl_reg.ren <= pwdata[4];
                ctrl_reg.tnb <= pwdata[3];
                ctrl_reg.rnb <= pwdata[2];
                ctrl_reg.ti <= pwdata[1];
                ctrl_reg.ri <= pwdata[0];
            end
            if (tx_done_reg) begin
                ctrl_reg.ti <= 1'b1;
            end
            if (rx_done_reg) begin
                ctrl_reg.ri <= 1'b1;
                // Stop bit in 8-bit mode, ninth bit in 9-bit modes, unchanged in shift mode
                ctrl_reg.rnb <= rnb_val_reg;
            end
        end
    end

    // Status flags: write one clears; framing error also clears on bit 7 zero in error view
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fe_reg <= 1'b0;
            brk_reg <= 1'b0;
        end else if (ce) begin
            if (wr && paddr == ADDR_STAT) begin
                fe_reg <= fe_reg & ~pwdata[STAT_FE];
                brk_reg <= brk_reg & ~pwdata[STAT_BRK];
            end
            if (wr && paddr == ADDR_CTRL && fes_reg && !pwdata[7]) begin
                fe_reg <= 1'b0;
            end
            if (fe_set_reg) begin
                fe_reg <= 1'b1;
            end
            if (break_reset_reg) begin
                brk_reg <= 1'b1;
            end
        end
    end

    // Transmitter, also runs both directions of shift mode
    logic [9:0] tx_sh_reg;
    logic [3:0] tx_cnt_reg;
    logic [3:0] tx_ph_reg;
    logic m0rx_reg; // Shift-mode transfer is a receive
    logic m0_bit_reg; // Sample taken at rising shift clock
    logic txd_reg;
    logic rxd_out_reg;
    logic rxd_oe_reg;
    logic tx_go;
    logic m0_rx_go;
    // Data writes while busy are dropped
    assign tx_go = wr && paddr == ADDR_DATA && tx_st == TX_IDLE;
    // Shift receive starts when enabled with receive flag clear
    assign m0_rx_go = mode == MODE_SHIFT && ctrl_reg.ren && !ctrl_reg.ri
                      && tx_st == TX_IDLE && !tx_go && !m0_done_reg && !rx_done_reg;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx_st <= TX_IDLE;
            tx_sh_reg <= 10'h000;
            tx_cnt_reg <= 4'h0;
            tx_ph_reg <= 4'h0;
            m0rx_reg <= 1'b0;
            m0_bit_reg <= 1'b0;
            txd_reg <= 1'b1;
            rxd_out_reg <= 1'b1;
            rxd_oe_reg <= 1'b0;
            tx_done_reg <= 1'b0;
            m0_done_reg <= 1'b0;
        end else if (ce) begin
            tx_done_reg <= 1'b0;
            m0_done_reg <= 1'b0;
            case (tx_st)
                TX_IDLE: begin
                    tx_ph_reg <= 4'h0;
                    if (tx_go || m0_rx_go) begin
                        tx_st <= TX_SHIFT;
                        m0rx_reg <= m0_rx_go;
                        txd_reg <= 1'b0; // Start bit, or shift clock low
                        if (mode == MODE_SHIFT) begin
                            // Data out on rxd, clock on txd
                            tx_sh_reg <= {2'h3, pwdata[7:0]};
                            tx_cnt_reg <= BITS_SH;
                            rxd_out_reg <= pwdata[0];
                            rxd_oe_reg <= tx_go;
                        end else begin
                            // Ninth slot is stop in 8-bit mode
                            tx_sh_reg <= {1'b1, (mode == MODE_8) | ctrl_reg.tnb, pwdata[7:0]};
                            tx_cnt_reg <= frame_bits(mode);
                        end
                    end
                end
                TX_SHIFT: begin
                    if (os_tick) begin
                        tx_ph_reg <= tx_ph_reg + 4'h1;
                        if (mode == MODE_SHIFT) begin
                            if (tx_ph_reg == PH_MID) begin
                                txd_reg <= 1'b1; // Rising shift clock
                                m0_bit_reg <= rxd_in;
                            end
                            if (tx_ph_reg == PH_LAST) begin
                                // LSB first in both directions
                                tx_sh_reg <= m0rx_reg ? {2'h3, m0_bit_reg, tx_sh_reg[7:1]}
                                                      : {1'b1, tx_sh_reg[9:1]};
                                tx_cnt_reg <= tx_cnt_reg - 4'h1;
                                if (tx_cnt_reg == 4'h1) begin
                                    tx_st <= TX_IDLE;
                                    rxd_oe_reg <= 1'b0;
                                    tx_done_reg <= ~m0rx_reg;
                                    m0_done_reg <= m0rx_reg;
                                end else begin
                                    txd_reg <= 1'b0;
                                    rxd_out_reg <= tx_sh_reg[1];
                                end
                            end
                        end else if (tx_ph_reg == PH_LAST) begin
                            if (tx_cnt_reg == 4'h0) begin
                                // Stop bit finished
                                tx_st <= TX_IDLE;
                                tx_done_reg <= 1'b1;
                            end else begin
                                txd_reg <= tx_sh_reg[0];
                                tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
                                tx_cnt_reg <= tx_cnt_reg - 4'h1;
                            end
                        end
                    end
                end
                default: tx_st <= TX_IDLE;
            endcase
        end
    end

    // Asynchronous receiver, sixteen ticks per bit, one sample per bit
    eu_rx_t rx_st;
    logic [9:0] rx_sh_reg;
    logic [3:0] rx_cnt_reg;
    logic [3:0] rx_ph_reg;
    logic rxd_prev_reg;
    logic [3:0] rx_last;
    assign rx_last = frame_bits(mode) - 4'h1;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_st <= RX_IDLE;
            rx_sh_reg <= 10'h000;
            rx_cnt_reg <= 4'h0;
            rx_ph_reg <= 4'h0;
            rxd_prev_reg <= 1'b1;
            rx_data_reg <= 8'h00;
            rnb_val_reg <= 1'b0;
            rx_done_reg <= 1'b0;
            fe_set_reg <= 1'b0;
            break_reset_reg <= 1'b0;
        end else if (ce) begin
            rxd_prev_reg <= rxd_in;
            rx_done_reg <= 1'b0;
            fe_set_reg <= 1'b0;
            break_reset_reg <= 1'b0;
            if (m0_done_reg) begin
                // Shift-mode receive result
                rx_data_reg <= tx_sh_reg[7:0];
                rnb_val_reg <= ctrl_reg.rnb;
                rx_done_reg <= 1'b1;
            end
            case (rx_st)
                RX_IDLE: begin
                    rx_ph_reg <= 4'h0;
                    rx_cnt_reg <= 4'h0;
                    // Falling edge opens a frame
                    if (mode != MODE_SHIFT && ctrl_reg.ren && rxd_prev_reg && !rxd_in) begin
                        rx_st <= RX_START;
                    end
                end
                RX_START: begin
                    if (os_tick) begin
                        rx_ph_reg <= rx_ph_reg + 4'h1;
                        if (rx_ph_reg == PH_MID) begin
                            // Glitch filter: start must still be low mid-bit
                            rx_st <= rxd_in ? RX_IDLE : RX_DATA;
                            rx_ph_reg <= 4'h0;
                        end
                    end
                end
                RX_DATA: begin
                    if (os_tick) begin
                        rx_ph_reg <= rx_ph_reg + 4'h1;
                        if (rx_ph_reg == PH_LAST) begin
                            rx_sh_reg <= {rxd_in, rx_sh_reg[9:1]};
                            rx_cnt_reg <= rx_cnt_reg + 4'h1;
                            if (rx_cnt_reg == rx_last) begin
                                // This sample is the stop bit
                                rx_st <= RX_IDLE;
                                rx_done_reg <= 1'b1;
                                fe_set_reg <= ~rxd_in;
                                if (mode == MODE_8) begin
                                    rx_data_reg <= rx_sh_reg[9:2];
                                    rnb_val_reg <= rxd_in;
                                    break_reset_reg <= ~rxd_in
                                                       && rx_sh_reg[9:2] == 8'h00;
                                end else begin
                                    rx_data_reg <= rx_sh_reg[8:1];
                                    rnb_val_reg <= rx_sh_reg[9]; // Stop dropped
                                    break_reset_reg <= ~rxd_in
                                                       && rx_sh_reg[9:1] == 9'h000;
                                end
                            end
                        end
                    end
                end
                default: rx_st <= RX_IDLE;
            endcase
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign txd = txd_reg;
    assign rxd_out = rxd_out_reg;
    assign rxd_oe = rxd_oe_reg;
    assign break_reset = break_reset_reg;

    chk_brg_reload: assert property (@(posedge clk_sys) disable iff (rst)
        ce && brg_tick |=> brg_cnt_reg == $past({divh_reg, divl_reg}))
        else $error("generator did not reload the divisor");
    chk_tx_start: assert property (@(posedge clk_sys) disable iff (rst)
        ce && tx_go && mode != MODE_SHIFT |=> !txd && tx_st == TX_SHIFT)
        else $error("start bit not driven low");
    chk_shift_drive: assert property (@(posedge clk_sys) disable iff (rst)
        ce && tx_go && mode == MODE_SHIFT |=> rxd_oe && rxd_out == $past(pwdata[0]))
        else $error("shift mode does not drive first bit");
    chk_ninth_load: assert property (@(posedge clk_sys) disable iff (rst)
        ce && tx_go && mode[1] |=> tx_sh_reg[8] == $past(ctrl_reg.tnb))
        else $error("ninth bit not loaded");
    chk_half_rate: assert property (@(posedge clk_sys) disable iff (rst)
        ce && mode == MODE_9F && !bd_reg && os_tick
        |=> !os_tick || !ce || mode != MODE_9F || bd_reg)
        else $error("fixed rate not halved");
    chk_fe_view: assert property (@(posedge clk_sys) disable iff (rst)
        ce && psel && penable && !pready_reg && !pwrite && paddr == ADDR_CTRL && fes_reg
        |=> prdata[7] == $past(fe_reg))
        else $error("bit 7 does not show framing error");
    chk_stop_flag: assert property (@(posedge clk_sys) disable iff (rst)
        ce && rx_done_reg && !m0_done_reg && mode == MODE_8
        |=> ctrl_reg.rnb == !$past(fe_set_reg))
        else $error("stop bit not stored");
    chk_break_flag: assert property (@(posedge clk_sys) disable iff (rst)
        ce && break_reset |=> brk_reg && fe_reg)
        else $error("break not recorded");
endmodule

/* rtl/eu_pkg.sv */
package eu_pkg;
    // Register byte addresses
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STAT = 5'h04;
    localparam logic [4:0] ADDR_PWR = 5'h08;
    localparam logic [4:0] ADDR_DIVL = 5'h0C;
    localparam logic [4:0] ADDR_DIVH = 5'h10;
    localparam logic [4:0] ADDR_SRC = 5'h14;
    localparam logic [4:0] ADDR_DATA = 5'h18;
    // Status bit positions
    localparam int STAT_FE = 0;
    localparam int STAT_BRK = 1;
    localparam int STAT_TXB = 2;
    // Power control bit positions
    localparam int PWR_BD = 7;
    localparam int PWR_FES = 6;
    // Source select bit: 1 picks the generator
    localparam int SRC_BRG = 0;
    // Serial modes
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_8 = 2'h1;
    localparam logic [1:0] MODE_9F = 2'h2;
    localparam logic [1:0] MODE_9V = 2'h3;
    // Oversample phases within one bit
    localparam logic [3:0] PH_MID = 4'h7;
    localparam logic [3:0] PH_LAST = 4'hF;
    // Bits after start: 8-bit frame, 9-bit frame, shift mode
    localparam logic [3:0] BITS_8 = 4'h9;
    localparam logic [3:0] BITS_9 = 4'hA;
    localparam logic [3:0] BITS_SH = 4'h8;
    // Control register fields, bit 7 down to bit 0 (bit 5 reads 0)
    typedef struct packed {
        logic msh;
        logic msl;
        logic ren;
        logic tnb;
        logic rnb;
        logic ti;
        logic ri;
    } eu_ctrl_t;
    localparam eu_ctrl_t CTRL_RST = 7'h00;
    // Receiver states
    typedef enum logic [2:0] {
        RX_IDLE = 3'b001,
        RX_START = 3'b010,
        RX_DATA = 3'b100
    } eu_rx_t;
    // Transmit and shift-mode states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SHIFT = 2'b10
    } eu_tx_t;
endpackage

/* verif/eu_peer.sv */
`timescale 1ns/1ps
// Far-side serial device: sends frames on rxd, decodes frames from txd
module eu_peer (
    input wire logic clk_sys,
    input wire logic txd,
    output logic rxd,
    input wire logic [7:0] bitc,
    input wire logic [3:0] nb
);
    logic [9:0] got; // Bits after start, LSB first
    event got_ev; // One event per decoded frame
    initial rxd = 1'h1; // Idle line sits high
    // Receiver: start on falling txd, sample mid-cell
    always @(negedge txd) begin
        repeat (bitc / 2) @(posedge clk_sys);
        got = '0;
        for (int i = 0; i < nb; i++) begin
            repeat (bitc) @(posedge clk_sys);
            got[i] = txd;
        end
        -> got_ev;
    end
    // Low start, nb bits LSB first, then idle high; call just after an edge
    task automatic send(input logic [9:0] f);
        rxd <= 1'h0;
        repeat (bitc) @(posedge clk_sys);
        for (int i = 0; i < nb; i++) begin
            rxd <= f[i];
            repeat (bitc) @(posedge clk_sys);
        end
        rxd <= 1'h1;
    endtask
endmodule

/* verif/eu_uart_tb.sv */
`timescale 1ns/1ps
module eu_uart_tb;
    import eu_pkg::*;
    logic clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic t1_ovf = 1'h0, brk_seen = 1'h0, rd_e; // Timer pulse, break latch, last slave error
    logic [4:0] paddr = 5'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_v, seed = 32'h00009A92;
    logic pready, pslverr, rxd_out, rxd_oe, txd, break_reset, peer_rxd;
    logic [7:0] bitc = 8'h20; // Peer bit length in clocks
    logic [3:0] nb = 4'h9; // Peer bits after start
    logic [9:0] exp_q[$]; // Expected frames seen by the peer
    int error_cnt = 0, n_tests = 0, cyc = 0;
    logic sh_on = 1'h0; // Shift mode running: peer decodes of txd are meaningless
    // Per case: mode, source, doubling, divisor, bit length in clocks
    logic [1:0] t_md[6] = '{MODE_8, MODE_8, MODE_8, MODE_9F, MODE_9V, MODE_9F};
    int t_sr[6] = '{1, 0, 0, 0, 1, 0};
    int t_db[6] = '{0, 0, 1, 1, 0, 0};
    int t_dv[6] = '{1, 0, 0, 0, 2, 0};
    int t_bc[6] = '{32, 32, 64, 16, 48, 32};
    // Shared rxd: design drives it only in shift mode
    wire logic rxd_w = rxd_oe ? rxd_out : peer_rxd;
    always #2.5 clk_sys = ~clk_sys;
    // Timer 1 overflow every second cycle
    always @(posedge clk_sys) t1_ovf <= ~t1_ovf;
    // Break pulse lasts one cycle, so latch it
    always @(posedge clk_sys) if (break_reset === 1'h1) brk_seen <= 1'h1;
    eu_uart #(.CPU_DIV(1)) eu_uart_inst (.clk_sys(clk_sys), .rst(rst), .ce(1'h1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_in(rxd_w),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd), .t1_ovf(t1_ovf),
        .break_reset(break_reset));
    eu_peer eu_peer_inst (.clk_sys(clk_sys), .txd(txd), .rxd(peer_rxd), .bitc(bitc), .nb(nb));
    // Verdict in one place
    task automatic final_report();
        $display("Counts: %0d compares, %0d mismatched", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard, well above the expected run length
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // APB cycle: setup, access held until pready sampled high
    task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        rd_v = prdata;
        rd_e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wait_ctl(input int b);
        do apb(1'h0, ADDR_CTRL, 32'h0); while (rd_v[b] !== 1'h1);
    endtask
    // Monitor: each frame the peer decodes outside shift mode takes the oldest note
    always begin
        @(eu_peer_inst.got_ev);
        if (!sh_on)
            cmp({22'h0, eu_peer_inst.got}, {22'h0, exp_q.pop_front()});
    end
    initial begin
        logic [31:0] d;
        logic [7:0] sh;
        time t0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'h0;
        apb(1'h0, ADDR_CTRL, 32'h0);
        cmp(rd_v, 32'h0);
        apb(1'h0, 5'h1C, 32'h0); // Unmapped place must be refused
        cmp({31'h0, rd_e}, 32'h1);
        $display("Reset and map test done");
        // Every asynchronous mode and rate source, one frame each way
        for (int k = 0; k < 6; k++) begin
            d = xs();
            bitc <= 8'(t_bc[k]);
            nb <= (t_md[k] == MODE_8) ? BITS_8 : BITS_9;
            apb(1'h1, ADDR_PWR, 32'(t_db[k]) << PWR_BD);
            apb(1'h1, ADDR_DIVL, 32'(t_dv[k]));
            apb(1'h1, ADDR_DIVH, 32'h0);
            apb(1'h1, ADDR_SRC, 32'(t_sr[k]));
            apb(1'h1, ADDR_CTRL, {24'h0, t_md[k], 1'h0, 1'h1, d[8], 3'h0});
            exp_q.push_back((t_md[k] == MODE_8) ? {2'h1, d[7:0]} : {1'h1, d[8:0]});
            apb(1'h1, ADDR_DATA, {24'h0, d[7:0]});
            wait_ctl(1);
            eu_peer_inst.send((t_md[k] == MODE_8) ? {2'h1, d[23:16]} : {1'h1, d[24:16]});
            wait_ctl(0);
            apb(1'h0, ADDR_DATA, 32'h0);
            cmp(rd_v, {24'h0, d[23:16]});
            apb(1'h0, ADDR_CTRL, 32'h0);
            cmp({31'h0, rd_v[2]}, (t_md[k] == MODE_8) ? 32'h1 : {31'h0, d[24]});
            apb(1'h1, ADDR_CTRL, {24'h0, t_md[k], 6'h10});
            $display("Mode case %0d done", k);
        end
        // Stop bit low gives a framing error; error select swaps bit 7
        eu_peer_inst.send(10'h0A5);
        wait_ctl(0);
        apb(1'h0, ADDR_STAT, 32'h0);
        cmp({31'h0, rd_v[STAT_FE]}, 32'h1);
        apb(1'h1, ADDR_PWR, 32'h40);
        apb(1'h0, ADDR_CTRL, 32'h0);
        cmp({31'h0, rd_v[7]}, 32'h1);
        apb(1'h1, ADDR_CTRL, 32'h10);
        apb(1'h0, ADDR_CTRL, 32'h0);
        cmp({31'h0, rd_v[7]}, 32'h0);
        apb(1'h1, ADDR_PWR, 32'h0);
        apb(1'h0, ADDR_CTRL, 32'h0);
        cmp({31'h0, rd_v[7]}, 32'h1);
        // All-zero frame with low stop is a break
        eu_peer_inst.send(10'h000);
        wait_ctl(0);
        apb(1'h0, ADDR_STAT, 32'h0);
        cmp({30'h0, rd_v[STAT_BRK], brk_seen}, 32'h3);
        $display("Framing and break test done");
        // Shift mode: data on rxd LSB first, taken at each rising shift clock
        sh_on = 1'h1;
        sh = 8'h00;
        t0 = 0;
        apb(1'h1, ADDR_CTRL, 32'h0);
        apb(1'h1, ADDR_DATA, {24'h0, d[15:8]});
        for (int i = 0; i < 8; i++) begin
            @(posedge txd);
            if (i == 0) t0 = $time;
            sh = {rxd_w, sh[7:1]};
        end
        cmp({24'h0, sh}, {24'h0, d[15:8]});
        cmp({31'h0, rxd_oe}, 32'h1);
        cmp(32'($time - t0), 32'h230);
        wait_ctl(1);
        $display("Shift mode test done");
        final_report();
    end
endmodule
